/* File: pvd_params.svh */
`ifndef PVD_PARAMS_SVH
`define PVD_PARAMS_SVH

// ************************************************************
// register offsets, byte addresses in configuration space
// ************************************************************
`define PVD_OFF_VC0_STATUS     12'h11A
`define PVD_OFF_VC1_CAP        12'h11C
`define PVD_OFF_VC1_CTRL       12'h120
`define PVD_OFF_VC1_STATUS     12'h126
`define PVD_OFF_LINK_DECL_HDR  12'h140
`define PVD_OFF_ELEM_SELF_DESC 12'h144

// ************************************************************
// reset values
// ************************************************************
`define PVD_RST_VC0_STATUS     16'h0002
`define PVD_RST_VC1_CAP        32'h00000000
`define PVD_RST_VC1_CTRL       32'h00000000
`define PVD_RST_VC1_STATUS     16'h0000
`define PVD_RST_LINK_DECL_HDR  32'h00010005
`define PVD_RST_ELEM_SELF_DESC 32'h02000100

// ************************************************************
// field positions and fixed field values
// ************************************************************
`define PVD_NEG_BIT            1
`define PVD_NEXT_CAP_PTR       12'h000
`define PVD_DECL_VERSION       4'h1
`define PVD_EXT_CAP_CODE       16'h0005
`define PVD_PORT_INDEX         8'h02
`define PVD_COMP_ID_RST        8'h00
`define PVD_COMP_ID_LSB        16
`define PVD_COMP_ID_LANE       2
`define PVD_LINK_ENTRY_COUNT   8'h01
`define PVD_NODE_KIND          4'h0

// ************************************************************
// timing counts
// ************************************************************
`define PVD_READ_LATENCY       1

`endif

/* File: pvd_pkg.sv */
package pvd_pkg;

  // negotiation progress of channel zero
  typedef enum logic {
    PVD_NEG_PENDING,
    PVD_NEG_DONE
  } pvd_neg_state_t;

  // which register dword a read selects
  typedef enum logic [2:0] {
    PVD_SEL_NONE,
    PVD_SEL_VC0_STATUS,
    PVD_SEL_VC1_CAP,
    PVD_SEL_VC1_CTRL,
    PVD_SEL_VC1_STATUS,
    PVD_SEL_DECL_HDR,
    PVD_SEL_SELF_DESC
  } pvd_sel_t;

  typedef logic [11:0] pvd_addr_t;
  typedef logic [31:0] pvd_data_t;
  typedef logic [3:0]  pvd_be_t;

endpackage

/* File: pvd_wo_if.sv */
`timescale 1ns/1ps

// ************************************************************
// write-once field carrier
// ************************************************************
interface pvd_wo_if #(parameter int W = 8);
  logic         wr_en;  // one-cycle write strobe
  logic [W-1:0] wdata;  // value offered by the write
  logic [W-1:0] value;  // current field content
  logic         locked; // first write already taken

  modport owner (output wr_en, output wdata, input value, input locked);
  modport field (input wr_en, input wdata, output value, output locked);
endinterface

/* File: pvd_write_once.sv */
`timescale 1ns/1ps
`include "pvd_params.svh"

module pvd_write_once #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  pvd_wo_if.field  wo
);
  import pvd_pkg::*;

  // ************************************************************
  // field state
  // ************************************************************
  logic [W-1:0] value_q;  // stored field
  logic [W-1:0] value_d;
  logic         locked_q; // set by the first write, held until reset
  logic         locked_d;

  // next value: only the first write lands
  always_comb
  begin
    value_d  = value_q;
    locked_d = locked_q;
    if (wo.wr_en && !locked_q)
    begin
      value_d  = wo.wdata;
      locked_d = 1'b1;
    end
  end

  // registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      value_q  <= RST_VAL;
      locked_q <= 1'b0;
    end
    else
    begin
      value_q  <= value_d;
      locked_q <= locked_d;
    end
  end

  assign wo.value  = value_q;
  assign wo.locked = locked_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_wo_hold_value: assert property (@(posedge sys_clk) disable iff (rst)
    locked_q |=> (value_q == $past(value_q) && locked_q))
    else $error("write-once field changed after lock");

  a_wo_first_take: assert property (@(posedge sys_clk) disable iff (rst)
    (wo.wr_en && !locked_q) |=> (locked_q && value_q == $past(wo.wdata)))
    else $error("first write to write-once field not taken");
endmodule

/* File: pvd_regs.sv */
// Overview of operation
// - status bit 1 shows channel zero negotiating
// - flag sets on reset, disable, link down
// - flag clears only on leaving FC_INIT2
// - channel one registers all read zero
// - declaration header next pointer reads zero
// - declaration header version reads one
// - declaration header capability code is 0005h
// - self description port index reads 02h
// - component identifier resets zero, writable once
// - self description reports one link entry
// - node kind zero, bits 7:4 zero
// - status reserved bits read zero, 0002h reset
`timescale 1ns/1ps
`include "pvd_params.svh"

module pvd_regs
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire pvd_pkg::pvd_addr_t cfg_addr,
  input  wire logic            cfg_rd,
  input  wire logic            cfg_wr,
  input  wire pvd_pkg::pvd_be_t   cfg_be,
  input  wire pvd_pkg::pvd_data_t cfg_wdata,
  output logic [31:0]          cfg_rdata,
  output logic                 cfg_rvalid,
  input  wire logic            vc0_disabled,
  input  wire logic            dl_down,
  input  wire logic            fc_init2_exit,
  output logic                 channel_zero_negotiating
);
  import pvd_pkg::*;

  // ************************************************************
  // dword decode constants
  // ************************************************************
  // printed offsets are byte addresses; the 16-bit status
  // registers sit in the upper half of their dword
  localparam pvd_addr_t OFF_VC0_STATUS = `PVD_OFF_VC0_STATUS;
  localparam pvd_addr_t OFF_VC1_CAP    = `PVD_OFF_VC1_CAP;
  localparam pvd_addr_t OFF_VC1_CTRL   = `PVD_OFF_VC1_CTRL;
  localparam pvd_addr_t OFF_VC1_STATUS = `PVD_OFF_VC1_STATUS;
  localparam pvd_addr_t OFF_DECL_HDR   = `PVD_OFF_LINK_DECL_HDR;
  localparam pvd_addr_t OFF_SELF_DESC  = `PVD_OFF_ELEM_SELF_DESC;

  // ************************************************************
  // negotiation state
  // ************************************************************
  pvd_neg_state_t neg_state_q; // channel zero progress
  pvd_neg_state_t neg_state_d;
  logic           neg_flag_q;  // registered copy for the pin
  logic           neg_flag_d;

  // next state: a set condition always beats the clear event,
  // so a link drop in the exit cycle leaves the flag pending
  always_comb
  begin
    neg_state_d = neg_state_q;
    case (neg_state_q)
      PVD_NEG_PENDING:
      begin
        // leave only on a clean FC_INIT2 exit
        if (fc_init2_exit && !vc0_disabled && !dl_down)
          neg_state_d = PVD_NEG_DONE;
      end
      PVD_NEG_DONE:
      begin
        // disable or DL_Down restarts negotiation
        if (vc0_disabled || dl_down)
          neg_state_d = PVD_NEG_PENDING;
      end
      default:
        neg_state_d = PVD_NEG_PENDING;
    endcase
    neg_flag_d = (neg_state_d == PVD_NEG_PENDING);
  end

  // negotiation registers; reset lands in pending
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      neg_state_q <= PVD_NEG_PENDING;
      neg_flag_q  <= 1'b1;
    end
    else
    begin
      neg_state_q <= neg_state_d;
      neg_flag_q  <= neg_flag_d;
    end
  end

  // ************************************************************
  // write-once component identifier
  // ************************************************************
  pvd_wo_if #(.W(8)) comp_id_if ();

  // only byte lane 2 of the self description dword carries a
  // writable field; every other written bit is dropped quietly
  assign comp_id_if.wr_en = cfg_wr && cfg_be[`PVD_COMP_ID_LANE]
                            && (cfg_addr[11:2] == OFF_SELF_DESC[11:2]);
  assign comp_id_if.wdata = cfg_wdata[`PVD_COMP_ID_LSB +: 8];

  // holds the first value written until the next reset
  pvd_write_once #(
    .W       (8),
    .RST_VAL (`PVD_COMP_ID_RST)
  ) u_comp_id (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wo      (comp_id_if.field)
  );

  // ************************************************************
  // read path
  // ************************************************************
  pvd_sel_t  rd_sel;       // decoded dword
  pvd_data_t rd_word;      // assembled dword
  logic [31:0] rdata_q;    // read data held to the next read
  logic [31:0] rdata_d;
  logic        rvalid_q;   // one-cycle read answer
  logic        rvalid_d;

  // address decode on dword boundary
  always_comb
  begin
    rd_sel = PVD_SEL_NONE;
    case (cfg_addr[11:2])
      OFF_VC0_STATUS[11:2]: rd_sel = PVD_SEL_VC0_STATUS;
      OFF_VC1_CAP[11:2]:    rd_sel = PVD_SEL_VC1_CAP;
      OFF_VC1_CTRL[11:2]:   rd_sel = PVD_SEL_VC1_CTRL;
      OFF_VC1_STATUS[11:2]: rd_sel = PVD_SEL_VC1_STATUS;
      OFF_DECL_HDR[11:2]:   rd_sel = PVD_SEL_DECL_HDR;
      OFF_SELF_DESC[11:2]:  rd_sel = PVD_SEL_SELF_DESC;
      default:              rd_sel = PVD_SEL_NONE;
    endcase
  end

  // dword contents; unmapped dwords read zero
  always_comb
  begin
    rd_word = 32'h00000000;
    case (rd_sel)
      PVD_SEL_VC0_STATUS:
      begin
        // reserved bits 15:2 and 0 stay zero
        rd_word[31:16] = `PVD_RST_VC0_STATUS & 16'h0000;
        rd_word[16 + `PVD_NEG_BIT] = neg_flag_q;
      end
      PVD_SEL_VC1_CAP:
        rd_word = `PVD_RST_VC1_CAP;
      PVD_SEL_VC1_CTRL:
        rd_word = `PVD_RST_VC1_CTRL;
      PVD_SEL_VC1_STATUS:
        rd_word[31:16] = `PVD_RST_VC1_STATUS;
      PVD_SEL_DECL_HDR:
      begin
        rd_word[31:20] = `PVD_NEXT_CAP_PTR;
        rd_word[19:16] = `PVD_DECL_VERSION;
        rd_word[15:0]  = `PVD_EXT_CAP_CODE;
      end
      PVD_SEL_SELF_DESC:
      begin
        rd_word[31:24] = `PVD_PORT_INDEX;
        rd_word[23:16] = comp_id_if.value;
        rd_word[15:8]  = `PVD_LINK_ENTRY_COUNT;
        rd_word[7:4]   = 4'h0;
        rd_word[3:0]   = `PVD_NODE_KIND;
      end
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // read data is held between reads so slow masters may sample late
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = cfg_rd;
    if (cfg_rd)
      rdata_d = rd_word;
  end

  // read registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // outputs straight from flip-flops
  assign cfg_rdata                = rdata_q;
  assign cfg_rvalid               = rvalid_q;
  assign channel_zero_negotiating = neg_flag_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence seq_rd_hdr;
    cfg_rd && (cfg_addr[11:2] == OFF_DECL_HDR[11:2]);
  endsequence

  sequence seq_rd_esd;
    cfg_rd && (cfg_addr[11:2] == OFF_SELF_DESC[11:2]);
  endsequence

  sequence seq_rd_vc1;
    cfg_rd && ((cfg_addr[11:2] == OFF_VC1_CAP[11:2]) || (cfg_addr[11:2] == OFF_VC1_CTRL[11:2])
               || (cfg_addr[11:2] == OFF_VC1_STATUS[11:2]));
  endsequence

  // read of the dword whose upper half is the channel zero status
  sequence seq_rd_vc0;
    cfg_rd && (cfg_addr[11:2] == OFF_VC0_STATUS[11:2]);
  endsequence

  a_neg_after_reset: assert property (@(posedge sys_clk)
    $fell(rst) |-> channel_zero_negotiating)
    else $error("negotiating flag not set after reset");

  a_neg_set_cause: assert property (@(posedge sys_clk) disable iff (rst)
    // a clean exit in the cycle after the cause ends may clear it again
    (vc0_disabled || dl_down) |=> channel_zero_negotiating ##1 (channel_zero_negotiating || $past(fc_init2_exit)))
    else $error("negotiating flag not set on disable or link down");

  a_neg_clear_only: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(channel_zero_negotiating) |-> $past(fc_init2_exit) && !$past(dl_down) && !$past(vc0_disabled))
    else $error("negotiating flag cleared without FC_INIT2 exit");

  a_neg_clear_time: assert property (@(posedge sys_clk) disable iff (rst)
    (fc_init2_exit && !vc0_disabled && !dl_down) |=> !channel_zero_negotiating)
    else $error("negotiating flag not cleared after FC_INIT2 exit");

  a_read_answer: assert property (@(posedge sys_clk) disable iff (rst)
    // the answer comes a fixed latency after the request edge
    cfg_rd |-> ##`PVD_READ_LATENCY cfg_rvalid)
    else $error("read not answered one cycle later");

  a_vc0_status_read: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_vc0
    |=> (cfg_rdata == {14'h0000, $past(channel_zero_negotiating), 17'h00000}))
    else $error("channel zero status read wrong");

  a_vc1_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_vc1 |=> (cfg_rdata == 32'h00000000))
    else $error("channel one register not zero");

  a_hdr_read: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_hdr |=> (cfg_rdata == `PVD_RST_LINK_DECL_HDR))
    else $error("declaration header read wrong");

  a_esd_read: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_esd |=> (cfg_rdata[31:24] == 8'h02 && cfg_rdata[15:0] == 16'h0100
                    && cfg_rdata[23:16] == $past(comp_id_if.value)))
    else $error("self description read wrong");

  a_esd_low_zero: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_esd |=> (cfg_rdata[7:0] == 8'h00))
    else $error("node kind or reserved bits not zero");

  a_hdr_fields: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_hdr |=> (cfg_rdata[19:16] == 4'h1 && cfg_rdata[15:0] == 16'h0005))
    else $error("declaration version or capability code wrong");

  a_vc0_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    seq_rd_vc0 |=> (cfg_rdata[31:18] == 14'h0000 && cfg_rdata[16:0] == 17'h00000))
    else $error("channel zero status reserved bits not zero");

  // pending is left only through a clean exit; any other cycle keeps it
  a_neg_hold_pending: assert property (@(posedge sys_clk) disable iff (rst)
    (channel_zero_negotiating && !fc_init2_exit) |=> channel_zero_negotiating)
    else $error("negotiating flag dropped without exit event");

  // ************************************************************
  // write side checks
  // ************************************************************
  // a write off lane 2 or off the self description dword is dropped
  a_id_lane_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg_wr && !comp_id_if.wr_en) |=> $stable(comp_id_if.value))
    else $error("component identifier changed by a gated write");

  // any accepted write to the field closes it until reset
  a_id_lock_taken: assert property (@(posedge sys_clk) disable iff (rst)
    comp_id_if.wr_en |=> comp_id_if.locked)
    else $error("component identifier not locked after write");

  // writes give no answer and leave the held read data alone
  a_wr_silent: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg_wr && !cfg_rd) |=> (!cfg_rvalid && $stable(cfg_rdata)))
    else $error("write disturbed the read answer");

  // no answer appears without a read one cycle before
  a_read_single: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg_rd |=> !cfg_rvalid)
    else $error("read answer without a read");
endmodule

/* File: pvd_regs_tb.sv */
`timescale 1ns/1ps

module pvd_regs_tb;
  import pvd_pkg::*;

  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic        sys_clk;
  logic        rst;
  pvd_addr_t   cfg_addr;
  logic        cfg_rd;
  logic        cfg_wr;
  pvd_be_t     cfg_be;
  pvd_data_t   cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid;
  logic        vc0_disabled;
  logic        dl_down;
  logic        fc_init2_exit;
  logic        channel_zero_negotiating;
  int          miscompares;
  int          n_compared;

  // device under test, every port exercised
  pvd_regs dut (
    .sys_clk                 (sys_clk),
    .rst                     (rst),
    .cfg_addr                (cfg_addr),
    .cfg_rd                  (cfg_rd),
    .cfg_wr                  (cfg_wr),
    .cfg_be                  (cfg_be),
    .cfg_wdata               (cfg_wdata),
    .cfg_rdata               (cfg_rdata),
    .cfg_rvalid              (cfg_rvalid),
    .vc0_disabled            (vc0_disabled),
    .dl_down                 (dl_down),
    .fc_init2_exit           (fc_init2_exit),
    .channel_zero_negotiating(channel_zero_negotiating)
  );

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare a data word, four-state exact
  task automatic cmp32(input pvd_data_t got, input pvd_data_t exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // compare a single flag
  task automatic cmp1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // one read; the answer must come one cycle after the request edge
  task automatic chk_rd(input pvd_addr_t a, input pvd_data_t exp);
    int i;
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_rd   = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    i = 0;
    // bounded wait so a missing answer cannot hang the run
    while (cfg_rvalid !== 1'b1 && i < 4)
    begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 4)
    begin
      miscompares++;
      $display("unexpected at %0t: no read answer", $time);
      stop_test();
    end
    else
    begin
      cmp1(i == 0, 1'b1, "read latency");
      cmp32(cfg_rdata, exp, "read data");
      // the answer stands one cycle, the data until the next read
      @(negedge sys_clk);
      cmp1(cfg_rvalid, 1'b0, "answer one cycle");
      cmp32(cfg_rdata, exp, "read data held");
    end
  endtask

  // one write, one cycle long
  task automatic wr(input pvd_addr_t a, input pvd_be_t be, input pvd_data_t d);
    @(negedge sys_clk);
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask

  // one-cycle pulse of the flow-control exit event
  task automatic pulse_fc;
    @(negedge sys_clk);
    fc_init2_exit = 1'b1;
    @(negedge sys_clk);
    fc_init2_exit = 1'b0;
  endtask

  // reset held for twelve cycles, driven off the sampling edge
  task automatic do_reset;
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset contents of every dword, half-word aliases and a hole
  task automatic t_reset_values;
    pvd_addr_t a[9] = '{12'h118, 12'h11A, 12'h11C, 12'h120, 12'h124, 12'h126, 12'h140, 12'h144, 12'h200};
    pvd_data_t e[9] = '{32'h00020000, 32'h00020000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00010005, 32'h02000100, 32'h0};
    cmp1(channel_zero_negotiating, 1'b1, "flag after reset");
    for (int k = 0; k < 9; k++)
      chk_rd(a[k], e[k]);
    $display("test reset_values done");
  endtask

  // flag sets on disable and link down, clears only on a clean exit
  task automatic t_negotiation;
    pulse_fc();
    cmp1(channel_zero_negotiating, 1'b0, "clear on exit");
    chk_rd(12'h118, 32'h00000000);
    dl_down = 1'b1;
    @(negedge sys_clk);
    cmp1(channel_zero_negotiating, 1'b1, "set on link down");
    pulse_fc();
    cmp1(channel_zero_negotiating, 1'b1, "exit while down");
    dl_down = 1'b0;
    repeat (3) @(negedge sys_clk);
    cmp1(channel_zero_negotiating, 1'b1, "no clear without exit");
    pulse_fc();
    cmp1(channel_zero_negotiating, 1'b0, "clear after up");
    vc0_disabled = 1'b1;
    @(negedge sys_clk);
    cmp1(channel_zero_negotiating, 1'b1, "set on disable");
    pulse_fc();
    cmp1(channel_zero_negotiating, 1'b1, "exit while disabled");
    chk_rd(12'h11A, 32'h00020000);
    vc0_disabled = 1'b0;
    pulse_fc();
    cmp1(channel_zero_negotiating, 1'b0, "clear after enable");
    // software confirms the clear before it uses the channel
    chk_rd(12'h11A, 32'h00000000);
    $display("test negotiation done");
  endtask

  // component id: lane gating, first write wins, read-only places stay put
  task automatic t_write_once;
    wr(12'h144, 4'hB, 32'hFF33FFFF);
    chk_rd(12'h144, 32'h02000100);
    wr(12'h144, 4'hF, 32'hFF5AFFFF);
    chk_rd(12'h144, 32'h025A0100);
    wr(12'h144, 4'h4, 32'h00A50000);
    chk_rd(12'h144, 32'h025A0100);
    wr(12'h140, 4'hF, 32'hFFFFFFFF);
    chk_rd(12'h140, 32'h00010005);
    wr(12'h11C, 4'hF, 32'hFFFFFFFF);
    chk_rd(12'h11C, 32'h00000000);
    wr(12'h118, 4'hF, 32'hFFFFFFFF);
    chk_rd(12'h118, 32'h00000000);
    $display("test write_once done");
  endtask

  // a reset in mid-run restores the flag and unlocks the id
  task automatic t_second_reset;
    do_reset();
    cmp1(channel_zero_negotiating, 1'b1, "flag after second reset");
    chk_rd(12'h144, 32'h02000100);
    wr(12'h144, 4'h4, 32'h003C0000);
    chk_rd(12'h144, 32'h023C0100);
    $display("test second_reset done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    sys_clk       = 1'b0;
    rst           = 1'b1;
    cfg_addr      = 12'h000;
    cfg_rd        = 1'b0;
    cfg_wr        = 1'b0;
    cfg_be        = 4'h0;
    cfg_wdata     = 32'h00000000;
    vc0_disabled  = 1'b0;
    dl_down       = 1'b0;
    fc_init2_exit = 1'b0;
    miscompares   = 0;
    n_compared    = 0;
    do_reset();
    t_reset_values();
    t_negotiation();
    t_write_once();
    t_second_reset();
    stop_test();
  end
endmodule
